// File: logic/flash_host_pkg.sv
// package: timing counts and encodings for the flash host controller
package flash_host_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CLK_NS = 25;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SECTOR_LO = 12;
  localparam int SECTOR_HI = 18;
  // times in their own units
  localparam int RESET_PULSE_NS = 500;
  localparam int READY_BUSY_US = 20;
  localparam int READY_IDLE_NS = 500;
  localparam int RESET_HIGH_NS = 50;
  localparam int HV_SETUP_US = 4;
  localparam int OE_SETUP_US = 4;
  localparam int WP_MIN_NS = 100;
  localparam int WP_PROTECT_US = 10;
  localparam int WP_UNPROTECT_MS = 12;
  localparam int ACCESS_NS = 70;
  localparam int WRITE_PULSE_NS = 35;
  // derived cycle counts, least times rounded up
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_BUSY_CYC = READY_BUSY_US * CLK_MHZ;
  localparam int READY_IDLE_CYC = (READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_HIGH_CYC = (RESET_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HV_SETUP_CYC = HV_SETUP_US * CLK_MHZ;
  localparam int OE_SETUP_CYC = OE_SETUP_US * CLK_MHZ;
  localparam int WP_MIN_CYC = (WP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_PROTECT_CYC = WP_PROTECT_US * CLK_MHZ;
  localparam int WP_UNPROTECT_CYC = WP_UNPROTECT_MS * 1000 * CLK_MHZ;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;
  // host commands
  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_WAIT_POLL, CMD_WAIT_TOGGLE, CMD_RESET,
    CMD_HV_ENTER, CMD_HV_EXIT, CMD_PROTECT_PULSE
  } cmd_t;
endpackage

// File: logic/flash_cycle_timer.sv
// module: loadable down counter that flags expiry
`timescale 1ns/10ps
module flash_cycle_timer (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [flash_host_pkg::CNT_W-1:0] count,
  output logic done
);
  logic [flash_host_pkg::CNT_W-1:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else begin
      done <= !load && (cnt_reg <= flash_host_pkg::CNT_W'(1));
    end
  end
endmodule

// File: logic/flash_host_ctrl.sv
// module: host-side controller driving a parallel nor flash over its pins
`timescale 1ns/10ps
module flash_host_ctrl #(
  parameter logic [19:0] UNPROTECT_CYC = 20'(flash_host_pkg::WP_UNPROTECT_CYC),
  parameter logic [19:0] READY_CYC = 20'(flash_host_pkg::READY_BUSY_CYC)
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic [2:0] req_cmd,
  input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] req_data,
  input wire logic req_erase,
  input wire logic req_unprotect,
  output logic req_ready,
  output logic rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic high_voltage_level,
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i
);
  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic [flash_host_pkg::DATA_W-1:0] dq_meta_reg;
  logic [flash_host_pkg::DATA_W-1:0] dq_sync_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= flash_dq_i;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // state and timer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_WAIT, ST_WR_PULSE, ST_WR_HIGH, ST_POLL_RD, ST_POLL_CHK,
    ST_RST_LOW, ST_RST_WAIT, ST_HV_SETUP, ST_OE_SETUP, ST_PP_PULSE, ST_RECOVER
  } state_t;
  state_t state_reg;
  logic tmr_load;
  logic [flash_host_pkg::CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic toggle_mode_reg;
  logic erase_reg;
  logic unprot_reg;
  logic busy_seen_reg;
  logic have_prev_reg;
  logic prev_toggle_reg;
  logic [flash_host_pkg::DATA_W-1:0] exp_reg;

  flash_cycle_timer u_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  function automatic logic [flash_host_pkg::CNT_W-1:0] cyc(input int n);
    cyc = flash_host_pkg::CNT_W'(n);
  endfunction

  // polling bit says done: true data after program, 1 after erase
  function automatic logic poll_done(input logic [15:0] d, input logic [15:0] e,
                                     input logic er);
    poll_done = er ? d[flash_host_pkg::POLL_BIT] :
      (d[flash_host_pkg::POLL_BIT] == e[flash_host_pkg::POLL_BIT]);
  endfunction

  logic acc;
  assign acc = req_valid && req_ready;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    unique case (state_reg)
      ST_IDLE: begin
        if (acc) begin
          tmr_load = 1'b1;
          unique case (req_cmd)
            flash_host_pkg::CMD_READ: tmr_count = cyc(flash_host_pkg::ACCESS_CYC);
            flash_host_pkg::CMD_RESET: tmr_count = cyc(flash_host_pkg::RESET_PULSE_CYC);
            flash_host_pkg::CMD_HV_ENTER: tmr_count = cyc(flash_host_pkg::HV_SETUP_CYC);
            flash_host_pkg::CMD_PROTECT_PULSE: tmr_count = cyc(flash_host_pkg::OE_SETUP_CYC);
            default: tmr_count = cyc(flash_host_pkg::WRITE_PULSE_CYC);
          endcase
        end
      end
      default: ;
    endcase
    if (tmr_done) begin
      unique case (state_reg)
        ST_WR_PULSE, ST_OE_SETUP: begin
          tmr_load = 1'b1;
          tmr_count = (state_reg == ST_WR_PULSE) ? cyc(flash_host_pkg::WRITE_PULSE_CYC) :
            (unprot_reg ? UNPROTECT_CYC : cyc(flash_host_pkg::WP_PROTECT_CYC));
        end
        ST_RST_LOW: begin
          tmr_load = 1'b1;
          tmr_count = busy_seen_reg ? READY_CYC : cyc(flash_host_pkg::READY_IDLE_CYC);
        end
        ST_PP_PULSE, ST_RST_WAIT: begin
          tmr_load = 1'b1;
          tmr_count = cyc(flash_host_pkg::RESET_HIGH_CYC);
        end
        ST_WR_HIGH, ST_POLL_CHK: begin
          tmr_load = 1'b1;
          tmr_count = cyc(flash_host_pkg::ACCESS_CYC);
        end
        default: ;
      endcase
    end
  end

  logic poll_cmd_reg;
  logic fin;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      req_ready <= 1'b0;
      toggle_mode_reg <= 1'b0;
      erase_reg <= 1'b0;
      unprot_reg <= 1'b0;
      exp_reg <= '0;
      poll_cmd_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (acc) begin
            req_ready <= 1'b0;
            erase_reg <= req_erase;
            unprot_reg <= req_unprotect;
            exp_reg <= req_data;
            poll_cmd_reg <= (req_cmd == flash_host_pkg::CMD_WAIT_POLL) ||
              (req_cmd == flash_host_pkg::CMD_WAIT_TOGGLE);
            toggle_mode_reg <= (req_cmd == flash_host_pkg::CMD_WAIT_TOGGLE);
            unique case (req_cmd)
              flash_host_pkg::CMD_READ: state_reg <= ST_RD_WAIT;
              flash_host_pkg::CMD_RESET: state_reg <= ST_RST_LOW;
              flash_host_pkg::CMD_HV_ENTER: state_reg <= ST_HV_SETUP;
              flash_host_pkg::CMD_HV_EXIT: state_reg <= ST_RECOVER;
              flash_host_pkg::CMD_PROTECT_PULSE: state_reg <= ST_OE_SETUP;
              default: state_reg <= ST_WR_PULSE;
            endcase
          end
        end
        ST_RD_WAIT, ST_HV_SETUP, ST_RECOVER: if (tmr_done) state_reg <= ST_IDLE;
        ST_WR_PULSE: if (tmr_done) state_reg <= ST_WR_HIGH;
        ST_WR_HIGH: if (tmr_done) state_reg <= poll_cmd_reg ? ST_POLL_RD : ST_IDLE;
        ST_POLL_RD: state_reg <= ST_POLL_CHK;
        ST_POLL_CHK: if (tmr_done) state_reg <= ST_POLL_RD;
        ST_RST_LOW: if (tmr_done) state_reg <= ST_RST_WAIT;
        ST_RST_WAIT: if (tmr_done) state_reg <= ST_RECOVER;
        ST_OE_SETUP: if (tmr_done) state_reg <= ST_PP_PULSE;
        ST_PP_PULSE: if (tmr_done) state_reg <= ST_RECOVER;
      endcase
      if (state_reg == ST_POLL_CHK && tmr_done && fin) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // completion detection
  // ----------------------------------------------------------------
  assign fin = toggle_mode_reg ?
    (have_prev_reg && dq_sync_reg[flash_host_pkg::TOGGLE_BIT] == prev_toggle_reg) :
    poll_done(dq_sync_reg, exp_reg, erase_reg);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      have_prev_reg <= 1'b0;
      prev_toggle_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      have_prev_reg <= 1'b0;
    end else if (state_reg == ST_POLL_CHK && tmr_done) begin
      have_prev_reg <= 1'b1;
      prev_toggle_reg <= dq_sync_reg[flash_host_pkg::TOGGLE_BIT];
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_seen_reg <= 1'b0;
    end else if (state_reg == ST_POLL_RD || state_reg == ST_WR_HIGH) begin
      busy_seen_reg <= 1'b1;
    end else if (state_reg == ST_RECOVER) begin
      busy_seen_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == ST_RD_WAIT && tmr_done) begin
        rsp_valid <= 1'b1;
        rsp_data <= dq_sync_reg;
      end else if (state_reg == ST_POLL_CHK && tmr_done && fin) begin
        rsp_valid <= 1'b1;
        rsp_data <= dq_sync_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b0;
      high_voltage_level <= 1'b0;
      flash_addr <= '0;
      flash_dq_o <= '0;
      flash_dq_oe <= 1'b0;
    end else begin
      flash_reset_n <= !(state_reg == ST_RST_LOW || (state_reg == ST_IDLE && acc &&
        req_cmd == flash_host_pkg::CMD_RESET));
      if (state_reg == ST_IDLE && acc) begin
        flash_addr <= req_addr;
        flash_dq_o <= req_data;
        if (req_cmd == flash_host_pkg::CMD_HV_ENTER) high_voltage_level <= 1'b1;
        if (req_cmd == flash_host_pkg::CMD_HV_EXIT) high_voltage_level <= 1'b0;
      end
      flash_ce_n <= !(state_reg inside {ST_RD_WAIT, ST_WR_PULSE, ST_POLL_RD, ST_POLL_CHK,
        ST_OE_SETUP, ST_PP_PULSE} || (state_reg == ST_IDLE && acc &&
        req_cmd inside {flash_host_pkg::CMD_READ, flash_host_pkg::CMD_WRITE,
        flash_host_pkg::CMD_WAIT_POLL, flash_host_pkg::CMD_WAIT_TOGGLE,
        flash_host_pkg::CMD_PROTECT_PULSE}));
      // oe high in the gap state, so each status read is a fresh access
      flash_oe_n <= !(state_reg inside {ST_RD_WAIT, ST_POLL_CHK, ST_OE_SETUP, ST_PP_PULSE}
        || (state_reg == ST_IDLE && acc &&
        req_cmd inside {flash_host_pkg::CMD_READ, flash_host_pkg::CMD_PROTECT_PULSE}));
      flash_we_n <= !((state_reg == ST_WR_PULSE && !tmr_done) ||
        (state_reg == ST_OE_SETUP && tmr_done) || (state_reg == ST_PP_PULSE && !tmr_done)
        || (state_reg == ST_IDLE && acc && req_cmd inside {flash_host_pkg::CMD_WRITE,
        flash_host_pkg::CMD_WAIT_POLL, flash_host_pkg::CMD_WAIT_TOGGLE}));
      flash_dq_oe <= (state_reg == ST_WR_PULSE || state_reg == ST_WR_HIGH ||
        (state_reg == ST_IDLE && acc && req_cmd inside {flash_host_pkg::CMD_WRITE,
        flash_host_pkg::CMD_WAIT_POLL, flash_host_pkg::CMD_WAIT_TOGGLE})) &&
        !(state_reg == ST_WR_HIGH && tmr_done);
    end
  end
endmodule

// File: tb/flash_host_ctrl_properties.sv
// checker: pin timing properties of the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_properties #(
  parameter logic [19:0] READY_CYC = 20'h00320
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic rsp_valid,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic high_voltage_level,
  input wire logic flash_dq_oe
);
  int lo_cnt, hi_cnt, hv_cnt, oe_cnt, we_cnt;
  logic rst_q, alg, alg_rst;
  function automatic int sat(input int v);
    return (v < 1000000) ? v + 1 : v;
  endfunction
  // ----------------------------------------
  // cycle counters per pin level
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt <= 1000000;
      {hi_cnt, hv_cnt, oe_cnt, we_cnt} <= '0;
      {rst_q, alg, alg_rst} <= '0;
    end else begin
      rst_q <= flash_reset_n;
      lo_cnt <= (!flash_reset_n && rst_q) ? 1 : sat(lo_cnt);
      hi_cnt <= flash_reset_n ? sat(hi_cnt) : 0;
      hv_cnt <= high_voltage_level ? sat(hv_cnt) : 0;
      oe_cnt <= !flash_oe_n ? sat(oe_cnt) : 0;
      we_cnt <= !flash_we_n ? sat(we_cnt) : 0;
      if (!flash_reset_n && rst_q) begin
        alg_rst <= alg;
        alg <= 1'b0;
      end else if (!flash_we_n && flash_oe_n && !high_voltage_level) begin
        alg <= 1'b1;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  reset_low_a: assert property ($rose(flash_reset_n) |-> lo_cnt >= 20)
    else $error("reset pulse too short");
  idle_ready_a: assert property ($fell(flash_ce_n) |-> lo_cnt >= 20)
    else $error("access too soon after reset");
  busy_ready_a: assert property ($fell(flash_ce_n) && alg_rst |-> lo_cnt >= READY_CYC)
    else $error("access too soon after reset of running algorithm");
  high_before_read_a: assert property ($fell(flash_oe_n) |-> hi_cnt >= 2)
    else $error("read too soon after reset release");
  hv_setup_a: assert property ($fell(flash_we_n) && high_voltage_level |-> hv_cnt >= 160)
    else $error("write too soon after high voltage");
  oe_setup_a: assert property ($fell(flash_we_n) && !flash_oe_n |-> oe_cnt >= 160)
    else $error("output enable setup too short");
  pulse_width_a: assert property ($rose(flash_we_n) && !flash_oe_n |-> we_cnt >= 4)
    else $error("protect pulse too short");
  read_release_a: assert property (!flash_oe_n && flash_we_n |-> !flash_dq_oe)
    else $error("host drives data during status read");
  cover property (rsp_valid);
  cover property ($fell(flash_reset_n));
  cover property ($rose(flash_we_n) && high_voltage_level);
endmodule

// File: tb/flash_dev_model.sv
// model: flash device answering with status bits and array data
`timescale 1ns/10ps
module flash_dev_model #(
  parameter int PROG_NS = 9000,
  parameter int ERASE_NS = 20000
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic erase_sel,
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mem [int];
  logic [15:0] wdata = 16'h0000;
  logic er = 1'b0;
  logic tog = 1'b0;
  realtime done_t = 0;
  int q[$];
  initial dout = 16'h0000;
  // write with oe high starts the embedded algorithm, ignored while one is running
  always @(posedge we_n) begin
    if (!ce_n && oe_n && reset_n && $realtime >= done_t) begin
      wdata = din;
      er = erase_sel;
      done_t = $realtime + (erase_sel ? ERASE_NS : PROG_NS);
      q.delete();
      if (erase_sel) begin
        foreach (mem[k]) if (k[18:12] == addr[18:12]) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
      end else begin
        mem[addr] = (mem.exists(addr) ? mem[addr] : 16'hFFFF) & din;
      end
    end
  end
  always @(negedge reset_n) done_t = $realtime;
  always begin
    @(negedge oe_n or negedge ce_n or posedge oe_n);
    #1;
    if (!oe_n && !ce_n && reset_n) begin
      if ($realtime < done_t) begin
        tog = ~tog;
        dout = {8'h00, er ? 1'b0 : ~wdata[7], tog, 6'h00};
      end else begin
        dout = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      end
    end else begin
      dout = ~dout;
    end
  end
endmodule

// File: tb/flash_host_ctrl_tb.sv
// testbench: flash host controller against a behavioural flash device
`timescale 1ns/10ps
module flash_host_ctrl_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_cmd = 3'h0;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_data = 16'h0000;
  logic req_erase = 1'b0;
  logic req_unprotect = 1'b0;
  logic req_ready, rsp_valid, ce_n, oe_n, we_n, rst_n, hv, dq_oe;
  logic [15:0] rsp_data, dq_o, dev_q, got;
  logic [19:0] addr;
  wire logic [15:0] dq_i = dq_oe ? dq_o : dev_q;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc;
  always #12.5 ref_clk = ~ref_clk;
  flash_host_ctrl #(.UNPROTECT_CYC(20'h0001E)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
    .req_erase(req_erase), .req_unprotect(req_unprotect), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_n(rst_n), .high_voltage_level(hv), .flash_addr(addr),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  flash_dev_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
    .erase_sel(req_erase), .addr(addr), .din(dq_o), .dout(dev_q));
  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    cmp_count++;
    if (exp !== act) begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_ready();
    cyc = 0;
    do begin
      @(posedge ref_clk);
      cyc++;
      if (rsp_valid === 1'b1) got = rsp_data;
    end while (req_ready !== 1'b1 && cyc < 40000);
    if (cyc >= 40000) begin
      check(16'h0001, 16'h0000);
      complete_run();
    end
  endtask
  task automatic run(input flash_host_pkg::cmd_t c, input logic [19:0] a,
                     input logic [15:0] d, input logic e, input logic u);
    got = 'x;
    req_cmd <= c;
    req_addr <= a;
    req_data <= d;
    req_erase <= e;
    req_unprotect <= u;
    req_valid <= 1'b1;
    wait_ready();
    req_valid <= 1'b0;
    wait_ready();
  endtask
  task automatic t_blank();
    run(flash_host_pkg::CMD_READ, 20'h01234, 16'h0000, 1'b0, 1'b0);
    check(16'hFFFF, got);
    $display("test blank read done");
  endtask
  task automatic t_program(input flash_host_pkg::cmd_t c, input logic [19:0] a,
                           input logic [15:0] d);
    run(c, a, d, 1'b0, 1'b0);
    check(d, got);
    check(16'h0001, 16'(cyc >= 360));
    run(flash_host_pkg::CMD_READ, a, 16'h0000, 1'b0, 1'b0);
    check(d, got);
    $display("test program %h done", a);
  endtask
  task automatic t_erase();
    t_program(flash_host_pkg::CMD_WAIT_POLL, 20'h03010, 16'h1234);
    t_program(flash_host_pkg::CMD_WAIT_POLL, 20'h05010, 16'h4321);
    run(flash_host_pkg::CMD_WAIT_POLL, 20'h03FFF, 16'hFFFF, 1'b1, 1'b0);
    check(16'hFFFF, got);
    check(16'h0001, 16'(cyc >= 800));
    run(flash_host_pkg::CMD_READ, 20'h03010, 16'h0000, 1'b0, 1'b0);
    check(16'hFFFF, got);
    run(flash_host_pkg::CMD_READ, 20'h05010, 16'h0000, 1'b0, 1'b0);
    check(16'h4321, got);
    $display("test erase done");
  endtask
  task automatic t_reset();
    run(flash_host_pkg::CMD_RESET, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(16'h0001, 16'(cyc >= 820));
    run(flash_host_pkg::CMD_READ, 20'h05010, 16'h0000, 1'b0, 1'b0);
    check(16'h4321, got);
    run(flash_host_pkg::CMD_RESET, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(16'h0001, 16'(cyc >= 40 && cyc < 800));
    $display("test reset done");
  endtask
  task automatic t_hv();
    run(flash_host_pkg::CMD_HV_ENTER, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(16'h0001, {15'h0000, hv});
    run(flash_host_pkg::CMD_WRITE, 20'h00000, 16'hFFFF, 1'b0, 1'b0);
    run(flash_host_pkg::CMD_PROTECT_PULSE, 20'h00000, 16'h0000, 1'b0, 1'b0);
    run(flash_host_pkg::CMD_PROTECT_PULSE, 20'h00000, 16'h0000, 1'b0, 1'b1);
    run(flash_host_pkg::CMD_HV_EXIT, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(16'h0000, {15'h0000, hv});
    $display("test high voltage done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_blank();
    t_program(flash_host_pkg::CMD_WAIT_POLL, 20'h00200, 16'h5A3C);
    t_program(flash_host_pkg::CMD_WAIT_TOGGLE, 20'h00300, 16'hC3A5);
    t_erase();
    t_reset();
    t_hv();
    complete_run();
  end
endmodule
bind flash_host_ctrl flash_host_ctrl_properties #(.READY_CYC(READY_CYC)) chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .rsp_valid(rsp_valid), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
  .high_voltage_level(high_voltage_level), .flash_dq_oe(flash_dq_oe));
